// file: include/obt_pkg.sv
// constants shared by the octal registered bus transceiver
package obt_pkg;
	// data width of each port and of each storage register
	localparam int DATA_W = 8;
	// wishbone widths
	localparam int WB_ADR_W = 8;
	localparam int WB_DAT_W = 32;
	localparam int WB_SEL_W = 4;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STORED = 8'h04;
	localparam logic [7:0] OFS_PINS = 8'h08;
	localparam logic [7:0] OFS_LIVE = 8'h0c;
	// control register: write-one capture strobes
	localparam int CTRL_CAP_A_BIT = 0;
	localparam int CTRL_CAP_B_BIT = 1;
	// stored and live registers: a byte low, b byte high
	localparam int BYTE_A_LSB = 0;
	localparam int BYTE_B_LSB = 8;
	// pin status register fields
	localparam int PIN_EN_AB_BIT = 0;
	localparam int PIN_EN_BA_N_BIT = 1;
	localparam int PIN_SEL_AB_BIT = 2;
	localparam int PIN_SEL_BA_BIT = 3;
	localparam int PIN_DRV_B_BIT = 4;
	localparam int PIN_DRV_A_BIT = 5;
	// reset values
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [31:0] RST_WB_DAT = 32'h0000_0000;
	// width of the pin synchroniser bundle
	localparam int SYNC_W = 2 * DATA_W + 6;
	// synchroniser depth in clock cycles
	localparam int SYNC_STAGES = 2;
endpackage

// file: core/obt_sync2.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module obt_sync2
#(
	parameter int W = 1
)
(
	// clock
	input wire logic i_clk,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	// first stage, read only by the second
	logic [W-1:0] meta_q;

	// no reset: the chain flushes itself within two edges
	always_ff @(posedge i_clk)
	begin
		meta_q <= i_d;
		o_q <= meta_q;
	end
endmodule // obt_sync2
`default_nettype wire

// file: core/obt_transceiver.sv
// octal registered bus transceiver with a wishbone status port
//
// Notes on behaviour
// - non-inverting eight-bit transfer, one register per direction
// - b driven by enable high, a by enable low
// - both disabled isolates; both enabled drives both
// - each direction has its own source select
// - select low passes live, high drives stored
// - select changes give glitch-free driven outputs
// - capture clock rising edge loads its port
// - capture never gated by output enables
// - both enabled, selects low: buses hold themselves
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module obt_transceiver
	import obt_pkg::*;
(
	// clock and synchronous reset
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	// port a pins
	input wire logic [obt_pkg::DATA_W-1:0] I_PORT_A_BUS,
	output logic [obt_pkg::DATA_W-1:0] O_PORT_A_BUS,
	output logic [obt_pkg::DATA_W-1:0] O_PORT_A_BUS_OE,
	// port b pins
	input wire logic [obt_pkg::DATA_W-1:0] I_PORT_B_BUS,
	output logic [obt_pkg::DATA_W-1:0] O_PORT_B_BUS,
	output logic [obt_pkg::DATA_W-1:0] O_PORT_B_BUS_OE,
	// direction control pins
	input wire logic I_A_TO_B_DRIVE_ENABLE,
	input wire logic I_B_TO_A_DRIVE_ENABLE_N,
	input wire logic I_A_TO_B_SOURCE_SELECT,
	input wire logic I_B_TO_A_SOURCE_SELECT,
	// capture clock pins, sampled as levels
	input wire logic I_A_CAPTURE_CLOCK,
	input wire logic I_B_CAPTURE_CLOCK,
	// wishbone classic slave
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [obt_pkg::WB_ADR_W-1:0] I_WB_ADR,
	input wire logic [obt_pkg::WB_SEL_W-1:0] I_WB_SEL,
	input wire logic [obt_pkg::WB_DAT_W-1:0] I_WB_DAT,
	output logic [obt_pkg::WB_DAT_W-1:0] O_WB_DAT,
	output logic O_WB_ACK
);
	import obt_pkg::*;

	// synchronised pin bundle
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_s;
	// synchronised pin levels by name
	logic [DATA_W-1:0] live_a;
	logic [DATA_W-1:0] live_b;
	logic en_ab;
	logic en_ba_n;
	logic sel_ab;
	logic sel_ba;
	logic cap_a_lvl;
	logic cap_b_lvl;
	// previous capture clock levels for edge detection
	logic cap_a_prev_q;
	logic cap_b_prev_q;
	// capture requests from the pins or from software
	logic cap_a;
	logic cap_b;
	logic sw_cap_a;
	logic sw_cap_b;
	// storage registers, no reset
	logic [DATA_W-1:0] store_a_q;
	logic [DATA_W-1:0] store_b_q;
	// bus bookkeeping
	logic wb_req;
	logic wb_wr_now;
	logic [WB_DAT_W-1:0] rd_d;

	// returns true for an access to a given word offset
	function automatic logic hit(input logic [WB_ADR_W-1:0] adr,
		input logic [7:0] ofs);
		hit = (adr == ofs);
	endfunction

	// every pin level crosses two flip-flops before use
	assign pins_raw = {I_B_CAPTURE_CLOCK, I_A_CAPTURE_CLOCK,
		I_B_TO_A_SOURCE_SELECT, I_A_TO_B_SOURCE_SELECT,
		I_B_TO_A_DRIVE_ENABLE_N, I_A_TO_B_DRIVE_ENABLE,
		I_PORT_B_BUS, I_PORT_A_BUS};

	// data and capture clocks share one depth, so the sampled byte
	// lines up with the sampled edge
	obt_sync2 #(
		.W(SYNC_W)
	) u_sync (
		.i_clk(I_REF_CLK),
		.i_d(pins_raw),
		.o_q(pins_s)
	);

	// unpack the synchronised bundle
	assign live_a = pins_s[DATA_W-1:0];
	assign live_b = pins_s[2*DATA_W-1:DATA_W];
	assign en_ab = pins_s[2*DATA_W];
	assign en_ba_n = pins_s[2*DATA_W+1];
	assign sel_ab = pins_s[2*DATA_W+2];
	assign sel_ba = pins_s[2*DATA_W+3];
	assign cap_a_lvl = pins_s[2*DATA_W+4];
	assign cap_b_lvl = pins_s[2*DATA_W+5];

	// previous levels; reset high so a clock already high at reset
	// release is not taken as an edge
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			cap_a_prev_q <= 1'b1;
			cap_b_prev_q <= 1'b1;
		end
		else
		begin
			cap_a_prev_q <= cap_a_lvl;
			cap_b_prev_q <= cap_b_lvl;
		end
	end

	// wishbone handshake terms
	assign wb_req = I_WB_CYC & I_WB_STB;
	assign wb_wr_now = wb_req & I_WB_WE & O_WB_ACK;

	// software strobes act at the edge where the master sees ack
	assign sw_cap_a = wb_wr_now & hit(I_WB_ADR, OFS_CTRL) & I_WB_SEL[0]
		& I_WB_DAT[CTRL_CAP_A_BIT];
	assign sw_cap_b = wb_wr_now & hit(I_WB_ADR, OFS_CTRL) & I_WB_SEL[0]
		& I_WB_DAT[CTRL_CAP_B_BIT];

	// rising edges only; enables and selects play no part here
	assign cap_a = (cap_a_lvl & ~cap_a_prev_q) | sw_cap_a;
	assign cap_b = (cap_b_lvl & ~cap_b_prev_q) | sw_cap_b;

	// a-direction storage: samples port a even while it is driven,
	// so a byte driven out from b can land in both registers
	always_ff @(posedge I_REF_CLK)
	begin
		if (cap_a)
		begin
			store_a_q <= live_a;
		end
		// no edge: hold, whatever the clock level; no reset branch
	end

	// b-direction storage, the mirror of the a side
	always_ff @(posedge I_REF_CLK)
	begin
		if (cap_b)
		begin
			store_b_q <= live_b;
		end
		// no edge: hold; contents unknown until first load
	end

	// port b drive: the mux result is held in one flip-flop per bit,
	// so a select change moves straight from old to new value with
	// no decoding glitch between
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			O_PORT_B_BUS <= RST_DATA;
			O_PORT_B_BUS_OE <= '0;
		end
		else
		begin
			// live or stored source for b
			if (sel_ab)
			begin
				O_PORT_B_BUS <= store_a_q;
			end
			else
			begin
				O_PORT_B_BUS <= live_a;
			end
			// high enable drives b; low leaves it an input
			O_PORT_B_BUS_OE <= {DATA_W{en_ab}};
		end
	end

	// port a drive, active-low enable
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			O_PORT_A_BUS <= RST_DATA;
			O_PORT_A_BUS_OE <= '0;
		end
		else
		begin
			// live or stored source for a
			if (sel_ba)
			begin
				O_PORT_A_BUS <= store_b_q;
			end
			else
			begin
				// with both sides live the two buses feed each other
				// and hold once outside drivers let go
				O_PORT_A_BUS <= live_b;
			end
			O_PORT_A_BUS_OE <= {DATA_W{~en_ba_n}};
		end
	end

	// read data multiplexer; unmapped words read as zero
	always_comb
	begin
		rd_d = '0;
		if (hit(I_WB_ADR, OFS_STORED))
		begin
			rd_d[BYTE_A_LSB +: DATA_W] = store_a_q;
			rd_d[BYTE_B_LSB +: DATA_W] = store_b_q;
		end
		else if (hit(I_WB_ADR, OFS_PINS))
		begin
			rd_d[PIN_EN_AB_BIT] = en_ab;
			rd_d[PIN_EN_BA_N_BIT] = en_ba_n;
			rd_d[PIN_SEL_AB_BIT] = sel_ab;
			rd_d[PIN_SEL_BA_BIT] = sel_ba;
			rd_d[PIN_DRV_B_BIT] = O_PORT_B_BUS_OE[0];
			rd_d[PIN_DRV_A_BIT] = O_PORT_A_BUS_OE[0];
		end
		else if (hit(I_WB_ADR, OFS_LIVE))
		begin
			rd_d[BYTE_A_LSB +: DATA_W] = live_a;
			rd_d[BYTE_B_LSB +: DATA_W] = live_b;
		end
		else
		begin
			// control strobes and unmapped offsets read zero
			rd_d = '0;
		end
	end

	// ack one cycle after the request, dropped the cycle after;
	// every offset answers so a stray access never hangs the master
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			O_WB_ACK <= 1'b0;
			O_WB_DAT <= RST_WB_DAT;
		end
		else
		begin
			O_WB_ACK <= wb_req & ~O_WB_ACK;
			if (wb_req & ~O_WB_ACK & ~I_WB_WE)
			begin
				O_WB_DAT <= rd_d;
			end
		end
	end
endmodule // obt_transceiver
`default_nettype wire

// file: sim/obt_checker.sv
// port-level assertions for the octal registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
module obt_checker
	import obt_pkg::*;
(
	// clock, reset and pins watched
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire logic [obt_pkg::DATA_W-1:0] I_PORT_A_BUS,
	input wire logic [obt_pkg::DATA_W-1:0] I_PORT_B_BUS,
	input wire logic [obt_pkg::DATA_W-1:0] O_PORT_A_BUS,
	input wire logic [obt_pkg::DATA_W-1:0] O_PORT_B_BUS,
	input wire logic [obt_pkg::DATA_W-1:0] O_PORT_A_BUS_OE,
	input wire logic [obt_pkg::DATA_W-1:0] O_PORT_B_BUS_OE,
	input wire logic I_A_TO_B_DRIVE_ENABLE,
	input wire logic I_B_TO_A_DRIVE_ENABLE_N,
	input wire logic I_A_TO_B_SOURCE_SELECT,
	input wire logic I_B_TO_A_SOURCE_SELECT,
	input wire logic I_A_CAPTURE_CLOCK,
	// wishbone signals watched
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [obt_pkg::WB_ADR_W-1:0] I_WB_ADR,
	input wire logic [obt_pkg::WB_DAT_W-1:0] O_WB_DAT,
	input wire logic O_WB_ACK
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RESET);
	// start of a bus request
	sequence s_req;
		$rose(I_WB_CYC && I_WB_STB);
	endsequence
	// stored byte on b with no capture and no software access
	sequence s_quiet_b;
		(I_A_TO_B_SOURCE_SELECT && $stable(I_A_CAPTURE_CLOCK)
			&& !I_WB_CYC)[*6];
	endsequence
	a_ack_answer: assert property (s_req |=> O_WB_ACK)
		else $error("request not acknowledged");
	a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack longer than one cycle");
	a_unmapped_zero: assert property
		(s_req and (!I_WB_WE && I_WB_ADR > 8'h0c) |=> O_WB_DAT == 32'h0)
		else $error("unmapped read not zero");
	a_drive_b: assert property
		(I_A_TO_B_DRIVE_ENABLE[*4] |-> O_PORT_B_BUS_OE == 8'hff)
		else $error("b not driven");
	a_drive_a: assert property
		(!I_B_TO_A_DRIVE_ENABLE_N[*4] |-> O_PORT_A_BUS_OE == 8'hff)
		else $error("a not driven");
	a_isolate_b: assert property
		(!I_A_TO_B_DRIVE_ENABLE[*4] |-> O_PORT_B_BUS_OE == 8'h00)
		else $error("b driven while disabled");
	a_isolate_a: assert property
		(I_B_TO_A_DRIVE_ENABLE_N[*4] |-> O_PORT_A_BUS_OE == 8'h00)
		else $error("a driven while disabled");
	a_live_to_b: assert property (( I_A_TO_B_DRIVE_ENABLE &&
		!I_A_TO_B_SOURCE_SELECT && $stable(I_PORT_A_BUS))[*4]
		|-> O_PORT_B_BUS == I_PORT_A_BUS) else $error("b not live a");
	a_live_to_a: assert property ((!I_B_TO_A_DRIVE_ENABLE_N &&
		!I_B_TO_A_SOURCE_SELECT && $stable(I_PORT_B_BUS))[*4]
		|-> O_PORT_A_BUS == I_PORT_B_BUS) else $error("a not live b");
	a_stored_hold: assert property
		(s_quiet_b |-> $stable(O_PORT_B_BUS))
		else $error("stored byte moved");
endmodule // obt_checker
bind obt_transceiver obt_checker i_chk (.*);
`default_nettype wire

// file: sim/obt_far_bus.sv
// far-side bus logic sharing one eight-bit wire with the device
`timescale 1ns/1ps
`default_nettype none
module obt_far_bus
	import obt_pkg::*;
(
	input wire logic i_clk,
	// far drive request and byte
	input wire logic i_drv,
	input wire logic [obt_pkg::DATA_W-1:0] i_d,
	// device byte and enable
	input wire logic [obt_pkg::DATA_W-1:0] i_dev,
	input wire logic [obt_pkg::DATA_W-1:0] i_oe,
	output logic [obt_pkg::DATA_W-1:0] o_wire
);
	// level of the previous cycle; starts defined so an idle wire toggles
	logic [DATA_W-1:0] last_q = '0;
	always_ff @(posedge i_clk)
	begin
		last_q <= o_wire;
	end
	// undriven wire flips each cycle, so a stale level never passes
	always_comb
	begin
		// an enable not yet out of reset counts as not driving
		o_wire = (i_oe[0] === 1'b1) ? i_dev : (i_drv ? i_d : ~last_q);
	end
endmodule // obt_far_bus
`default_nettype wire

// file: sim/obt_transceiver_bench.sv
// self-checking bench for the octal registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
module obt_transceiver_bench;
	import obt_pkg::*;
	logic clk = '0, rst = '1, ea = '0, eb_n = '1, sa = '0, sb = '0;
	logic ca = '0, cb = '0, fa = '0, fb = '0, cyc = '0, stb = '0, we = '0;
	logic ack;
	logic [7:0] da = '0, db = '0, adr = '0, aw, bw, oa, ob, oea, oeb;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat, r;
	int failures = 0, compares = 0;
	always #25 clk = ~clk;
	obt_transceiver i_dut (.I_REF_CLK(clk), .I_RESET(rst),
		.I_PORT_A_BUS(aw), .O_PORT_A_BUS(oa), .O_PORT_A_BUS_OE(oea),
		.I_PORT_B_BUS(bw), .O_PORT_B_BUS(ob), .O_PORT_B_BUS_OE(oeb),
		.I_A_TO_B_DRIVE_ENABLE(ea), .I_B_TO_A_DRIVE_ENABLE_N(eb_n),
		.I_A_TO_B_SOURCE_SELECT(sa), .I_B_TO_A_SOURCE_SELECT(sb),
		.I_A_CAPTURE_CLOCK(ca), .I_B_CAPTURE_CLOCK(cb), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
		.I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack));
	obt_far_bus i_fa (.i_clk(clk), .i_drv(fa), .i_d(da), .i_dev(oa),
		.i_oe(oea), .o_wire(aw));
	obt_far_bus i_fb (.i_clk(clk), .i_drv(fb), .i_d(db), .i_dev(ob),
		.i_oe(oeb), .o_wire(bw));
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task conclude;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one classic cycle: the request stands until ack is seen high at a
	// rising edge; read data is taken and the request dropped at that edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'h1 && n < 20);
		if (ack !== 1'h1)
		begin
			failures++;
			conclude;
		end
		r = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask
	// reset leaves both ports isolated; unmapped place reads zero
	task t_iso;
		@(negedge clk);
		chk(oea, 8'h00);
		chk(oeb, 8'h00);
		bus(1'h1, 8'h10, 32'hffff);
		bus(1'h0, 8'h10, 32'h0);
		chk(r, 32'h0);
	endtask
	// live a byte reaches b unchanged, a stays an input
	task t_live;
		fa <= 1'h1; da <= 8'h5a; ea <= 1'h1;
		tick(4);
		@(negedge clk);
		chk(ob, 8'h5a);
		chk(oeb, 8'hff);
		chk(oea, 8'h00);
	endtask
	// captured byte is driven while live a moves on
	task t_store;
		tick(1);
		ca <= 1'h1;
		tick(3);
		ca <= 1'h0;
		tick(3);
		da <= 8'h33; sa <= 1'h1;
		tick(5);
		@(negedge clk);
		chk(ob, 8'h5a);
		bus(1'h0, OFS_STORED, 32'h0);
		// the b register has never been loaded, so its byte is masked
		chk({r[31:16], 8'h00, r[7:0]}, {24'h0, 8'h5a});
		sa <= 1'h0;
		tick(4);
		@(negedge clk);
		chk(ob, 8'h33);
	endtask
	// both clocks together load the one driven byte twice
	task t_both;
		tick(1);
		ca <= 1'h1; cb <= 1'h1;
		tick(3);
		ca <= 1'h0; cb <= 1'h0;
		tick(3);
		bus(1'h0, OFS_STORED, 32'h0);
		chk(r, 32'h3333);
	endtask
	// both directions live: buses keep their level once released
	task t_hold;
		// a byte that differs from both registers, so only the loop holds it
		da <= 8'hc3;
		tick(6);
		eb_n <= 1'h0;
		tick(4);
		@(negedge clk);
		chk(oea, 8'hff);
		tick(1);
		fa <= 1'h0;
		tick(8);
		@(negedge clk);
		chk(aw, 8'hc3);
		chk(bw, 8'hc3);
	endtask
	// select high: a then b clocked apart so both registers get one byte
	task t_stagger;
		eb_n <= 1'h1;
		fa <= 1'h1;
		da <= 8'h96;
		sa <= 1'h1;
		tick(4);
		ca <= 1'h1;
		tick(3);
		ca <= 1'h0;
		tick(3);
		cb <= 1'h1;
		tick(3);
		cb <= 1'h0;
		tick(3);
		bus(1'h0, OFS_STORED, 32'h0);
		chk(r, 32'h9696);
	endtask
	// software strobe loads b; stored b then drives a; status fields
	task t_soft;
		da <= 8'h69;
		sa <= 1'h0;
		tick(6);
		bus(1'h1, OFS_CTRL, 32'h2);
		bus(1'h0, OFS_STORED, 32'h0);
		chk(r, 32'h6996);
		da <= 8'ha5;
		tick(6);
		bus(1'h0, OFS_LIVE, 32'h0);
		chk(r, 32'ha5a5);
		sb <= 1'h1;
		eb_n <= 1'h0;
		tick(4);
		@(negedge clk);
		chk(oa, 8'h69);
		bus(1'h0, OFS_PINS, 32'h0);
		chk(r, 32'h39);
	endtask
	initial
	begin
		tick(3);
		rst <= 1'h0;
		tick(2);
		t_iso;
		t_live;
		t_store;
		t_both;
		t_hold;
		t_stagger;
		t_soft;
		conclude;
	end
endmodule // obt_transceiver_bench
`default_nettype wire
